// ### rtl/bla_setup_regs.sv
`timescale 1ns/1ps
// Behaviour
// RULE1: Mode field bits 1:0, default 01; x0 no correction, 01 internal.
// RULE2: Mode 11 corrects with the external offset, still reports average.
// RULE3: Time constant bits 4:2, default 100, sets loop follow rate.
// RULE4: Integrator holds inside deadband; bit 5: 0 is +/-4, 1 is +/-2.
// RULE5: First analogue register: bit 0 clamp, bit 1 bit-line test, off.
// RULE6: First register bits 3:2 pick white reference, reset 00.
// RULE7: First register bit 4 enables anti-blooming, off after reset.
// RULE8: First register bits 5..7 power down comparators and current source.
// RULE9: Second register bit 0 is standby, all but band-gap off.
// RULE10: Second register bits 1..5 power down individual circuits.
// RULE11: Bit 6 ramp common mode select, bit 7 comparator bias select.
// RULE12: Host should set voltage doubler bit 2 on 3.3V supply.
// RULE13: Converter bit 3 enables differential ramp, default on.
// RULE14: Bit 4 observed node, bit 5 ramps or test comparator; 1 and 0.
// RULE15: Converter bit 6 selects stepped ramp, default set.
// RULE16: Converter bits 1:0 reset 10; mode register bits 7:6 are 00.
// RULE17: External offset is 11-bit two's complement, -1024 to +1023.
// RULE18: Host reaches these as 8-bit indexed serial bus locations.
// RULE19: All registers read and write; unused bits read zero; reset defaults.
module bla_setup_regs
   import bla_pkg::*;
#(
   parameter int        AVG_LOG2 = 6,
   parameter logic [9:0] TARGET  = 10'h040
) (
   input  wire logic        sys_clk_in,
   input  wire logic        srst_in,
   input  wire logic [7:0]  reg_index_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   input  wire logic [7:0]  reg_wdata_in,
   output logic      [7:0]  reg_rdata_out,
   output logic             reg_hit_out,
   input  wire logic [10:0] ext_offset_in,
   input  wire logic [9:0]  black_pix_in,
   input  wire logic        black_valid_in,
   input  wire logic [9:0]  pix_in,
   input  wire logic        pix_valid_in,
   output logic      [9:0]  pix_out,
   output logic             pix_valid_out,
   output logic      [9:0]  black_avg_out,
   output logic             black_avg_valid_out,
   output logic             bl_clamp_en_out,
   output logic             bl_test_en_out,
   output logic      [1:0]  white_ref_sel_out,
   output logic             anti_bloom_en_out,
   output logic             diff_clk_cmp_off_out,
   output logic             sram_cmp_off_out,
   output logic             controlled_current_source_off_out,
   output logic             standby_out,
   output logic             ramp_gen_off_out,
   output logic             column_adc_off_out,
   output logic             column_regulator_off_out,
   output logic             audio_regulator_off_out,
   output logic             top_reference_voltage_amp_off_out,
   output logic             ramp_cm_sel_out,
   output logic             col_cmp_bias_sel_out,
   output logic             doubler_en_out,
   output logic             diff_ramp_en_out,
   output logic             view_cascode_out,
   output logic             test_cmp_sel_out,
   output logic             stepped_ramp_out,
   output logic      [1:0]  conv_reserved_out
);

   // ----------------------------------------------------------------
   // Parameter checks
   // ----------------------------------------------------------------
   if (AVG_LOG2 < 1 || AVG_LOG2 > 10) begin : g_bad_avg
      $error("AVG_LOG2 must lie in 1..10");
   end

   // ----------------------------------------------------------------
   // Register bank
   // ----------------------------------------------------------------
   logic [7:0] cancel_reg,  cancel_next;
   logic [7:0] afirst_reg,  afirst_next;
   logic [7:0] asecond_reg, asecond_next;
   logic [7:0] conv_reg,    conv_next;
   logic [7:0] rdata_reg,   rdata_next;
   logic       hit_reg,     hit_next;

   // Writes store only the implemented bits so unused ones read zero
   always_comb begin
      cancel_next  = cancel_reg;
      afirst_next  = afirst_reg;
      asecond_next = asecond_reg;
      conv_next    = conv_reg;
      if (reg_wr_in) begin                                    // [RULE19]
         unique case (reg_index_in)
            BLA_IDX_CANCEL:  cancel_next  = reg_wdata_in & BLA_MSK_CANCEL;
            BLA_IDX_AFIRST:  afirst_next  = reg_wdata_in;
            BLA_IDX_ASECOND: asecond_next = reg_wdata_in;
            BLA_IDX_CONV:    conv_next    = reg_wdata_in & BLA_MSK_CONV;
            default:         ;
         endcase
      end
   end

   // Read port; indexes outside this group answer zero, not a hit
   always_comb begin
      rdata_next = rdata_reg;
      hit_next   = hit_reg;
      if (reg_rd_in) begin                                    // [RULE18]
         hit_next = 1'b1;
         unique case (reg_index_in)
            BLA_IDX_CANCEL:  rdata_next = cancel_reg;         // [RULE16]
            BLA_IDX_AFIRST:  rdata_next = afirst_reg;
            BLA_IDX_ASECOND: rdata_next = asecond_reg;
            BLA_IDX_CONV:    rdata_next = conv_reg;
            default: begin
               rdata_next = 8'h00;
               hit_next   = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin                                      // [RULE19]
         cancel_reg  <= BLA_RST_CANCEL;                       // [RULE1]
         afirst_reg  <= BLA_RST_AFIRST;                       // [RULE5]
         asecond_reg <= BLA_RST_ASECOND;                      // [RULE9]
         conv_reg    <= BLA_RST_CONV;                         // [RULE16]
         rdata_reg   <= 8'h00;
         hit_reg     <= 1'b0;
      end else begin
         cancel_reg  <= cancel_next;
         afirst_reg  <= afirst_next;
         asecond_reg <= asecond_next;
         conv_reg    <= conv_next;
         rdata_reg   <= rdata_next;
         hit_reg     <= hit_next;
      end
   end

   assign reg_rdata_out = rdata_reg;
   assign reg_hit_out   = hit_reg;

   // ----------------------------------------------------------------
   // Analogue controls, straight from the register bits
   // ----------------------------------------------------------------
   assign bl_clamp_en_out      = afirst_reg[BLA_AF_CLAMP];     // [RULE5]
   assign bl_test_en_out       = afirst_reg[BLA_AF_TEST];      // [RULE5]
   assign white_ref_sel_out    = afirst_reg[BLA_AF_WREF_LSB +: 2]; // [RULE6]
   assign anti_bloom_en_out    = afirst_reg[BLA_AF_BLOOM];     // [RULE7]
   // Single-ended clock input stays alive when this is set
   assign diff_clk_cmp_off_out = afirst_reg[BLA_AF_PD_DIFF];   // [RULE8]
   assign sram_cmp_off_out     = afirst_reg[BLA_AF_PD_SRAM];   // [RULE8]
   assign controlled_current_source_off_out =
      afirst_reg[BLA_AF_PD_CCS];                               // [RULE8]
   // Band-gap is not on this list: it must keep running in standby
   assign standby_out          = asecond_reg[BLA_AS_STANDBY];  // [RULE9]
   assign ramp_gen_off_out     = asecond_reg[BLA_AS_PD_RAMP];  // [RULE10]
   assign column_adc_off_out   = asecond_reg[BLA_AS_PD_CADC];  // [RULE10]
   assign column_regulator_off_out =
      asecond_reg[BLA_AS_COLUMN_REGULATOR_OFF];                             // [RULE10]
   assign audio_regulator_off_out =
      asecond_reg[BLA_AS_AUDIO_REGULATOR_OFF];                             // [RULE10]
   assign top_reference_voltage_amp_off_out =
      asecond_reg[BLA_AS_PD_REFA];                             // [RULE10]
   assign ramp_cm_sel_out      = asecond_reg[BLA_AS_RAMP_CM];  // [RULE11]
   assign col_cmp_bias_sel_out = asecond_reg[BLA_AS_CMP_BIAS]; // [RULE11]
   // Left to software; the supply voltage is not visible here
   assign doubler_en_out       = conv_reg[BLA_CV_DOUBLER];     // [RULE12]
   assign diff_ramp_en_out     = conv_reg[BLA_CV_DIFFRAMP];    // [RULE13]
   assign view_cascode_out     = conv_reg[BLA_CV_VIEWCAS];     // [RULE14]
   assign test_cmp_sel_out     = conv_reg[BLA_CV_TESTCMP];     // [RULE14]
   assign stepped_ramp_out     = conv_reg[BLA_CV_STEPPED];     // [RULE15]
   assign conv_reserved_out    = conv_reg[1:0];                // [RULE16]

   // ----------------------------------------------------------------
   // Black pixel averaging, active in every mode
   // ----------------------------------------------------------------
   localparam int SUM_W = 10 + AVG_LOG2;
   logic [SUM_W-1:0]    sum_reg, sum_next;
   logic [AVG_LOG2-1:0] cnt_reg, cnt_next;
   logic [9:0]          avg_reg, avg_next;
   logic                avgv_reg, avgv_next;
   logic [SUM_W-1:0]    sum_full;

   // Power-of-two block size keeps the divide a plain shift
   always_comb begin
      sum_full  = sum_reg + SUM_W'(black_pix_in);
      sum_next  = sum_reg;
      cnt_next  = cnt_reg;
      avg_next  = avg_reg;
      avgv_next = 1'b0;
      if (black_valid_in) begin                               // [RULE1]
         cnt_next = cnt_reg + 1'b1;
         if (&cnt_reg) begin
            avg_next  = sum_full[SUM_W-1 -: 10];
            avgv_next = 1'b1;
            sum_next  = '0;
         end else begin
            sum_next  = sum_full;
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         sum_reg  <= '0;
         cnt_reg  <= '0;
         avg_reg  <= 10'h000;
         avgv_reg <= 1'b0;
      end else begin
         sum_reg  <= sum_next;
         cnt_reg  <= cnt_next;
         avg_reg  <= avg_next;
         avgv_reg <= avgv_next;
      end
   end

   assign black_avg_out       = avg_reg;
   assign black_avg_valid_out = avgv_reg;

   // ----------------------------------------------------------------
   // Offset loop
   // ----------------------------------------------------------------
   bla_loop_if lp ();
   assign lp.mode      = bla_mode_t'(cancel_reg[1:0]);
   assign lp.tc        = cancel_reg[BLA_CAN_TC_LSB +: 3];      // [RULE3]
   assign lp.narrow    = cancel_reg[BLA_CAN_NARROW];           // [RULE4]
   assign lp.avg       = avg_reg;
   assign lp.avg_valid = avgv_reg;

   bla_black_loop #(
      .TARGET (TARGET)
   ) u_loop (
      .sys_clk_in (sys_clk_in),
      .srst_in    (srst_in),
      .lp         (lp.loop)
   );

   // ----------------------------------------------------------------
   // Pixel correction
   // ----------------------------------------------------------------
   logic [9:0] pix_reg, pix_next;
   logic       pixv_reg, pixv_next;

   // Mode picks none, internal estimate or the external offset
   always_comb begin
      pixv_next = pix_valid_in;
      pix_next  = pix_reg;
      if (pix_valid_in) begin
         unique case (lp.mode)
            BLA_MODE_INT:                                     // [RULE1]
               pix_next = bla_sub_clamp(pix_in, lp.int_offset);
            BLA_MODE_EXT:                                     // [RULE2]
               pix_next = bla_sub_clamp(pix_in, ext_offset_in); // [RULE17]
            BLA_MODE_OFF0, BLA_MODE_OFF2:                     // [RULE1]
               pix_next = pix_in;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in) begin
         pix_reg  <= 10'h000;
         pixv_reg <= 1'b0;
      end else begin
         pix_reg  <= pix_next;
         pixv_reg <= pixv_next;
      end
   end

   assign pix_out       = pix_reg;
   assign pix_valid_out = pixv_reg;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_reset_defaults: assert property (@(posedge sys_clk_in)
      disable iff (srst_in)
      $fell(srst_in) |-> (cancel_reg == 8'h31 && afirst_reg == 8'h00
         && asecond_reg == 8'h00 && conv_reg == 8'h5a)) // [RULE19]
      else $error("Registers not at defaults after reset");

   a_mode_bypass: assert property (@(posedge sys_clk_in)
      disable iff (srst_in)
      (pix_valid_in && !cancel_reg[0]) |=>
         (pix_out == $past(pix_in) && pix_valid_out)) // [RULE1]
      else $error("Pixel altered while correction is off");

   a_mode_internal: assert property (@(posedge sys_clk_in)
      disable iff (srst_in)
      (pix_valid_in && cancel_reg[1:0] == 2'b01) |=>
         pix_out == bla_sub_clamp($past(pix_in),
                                  $past(lp.int_offset))) // [RULE1]
      else $error("Internal offset not applied");

   a_mode_external: assert property (@(posedge sys_clk_in)
      disable iff (srst_in)
      (pix_valid_in && cancel_reg[1:0] == 2'b11) |=>
         pix_out == bla_sub_clamp($past(pix_in),
                                  $past(ext_offset_in))) // [RULE2]
      else $error("External offset not applied");

   a_avg_block: assert property (@(posedge sys_clk_in)
      disable iff (srst_in)
      (black_valid_in && &cnt_reg) |=> black_avg_valid_out
         ##1 !black_avg_valid_out [*1]) // [RULE1]
      else $error("Average not reported after a full block");

   a_tc_follows: assert property (@(posedge sys_clk_in)
      disable iff (srst_in)
      (reg_wr_in && reg_index_in == 8'h72) |=>
         (lp.tc == $past(reg_wdata_in[4:2])
          && cancel_reg[7:6] == 2'b00)) // [RULE3]
      else $error("Time constant or unused bits wrong");

   a_standby_write: assert property (@(posedge sys_clk_in)
      disable iff (srst_in)
      (reg_wr_in && reg_index_in == 8'h76) |=>
         (standby_out == $past(reg_wdata_in[0])
          && col_cmp_bias_sel_out == $past(reg_wdata_in[7]))) // [RULE9]
      else $error("Second control register write lost");

   a_first_write: assert property (@(posedge sys_clk_in)
      disable iff (srst_in)
      (reg_wr_in && reg_index_in == 8'h75) |=>
         (white_ref_sel_out == $past(reg_wdata_in[3:2])
          && anti_bloom_en_out == $past(reg_wdata_in[4]))) // [RULE6]
      else $error("First control register write lost");

   a_read_back: assert property (@(posedge sys_clk_in)
      disable iff (srst_in)
      (reg_rd_in && reg_index_in == 8'h77 && !reg_wr_in) |=>
         (reg_rdata_out == conv_reg && reg_rdata_out[7] == 1'b0
          && reg_hit_out)) // [RULE19]
      else $error("Converter setup read back wrong");

endmodule : bla_setup_regs

// ### rtl/bla_pkg.sv
package bla_pkg;

   // ----------------------------------------------------------------
   // Register indexes on the serial control bus
   // ----------------------------------------------------------------
   localparam logic [7:0] BLA_IDX_CANCEL  = 8'h72;
   localparam logic [7:0] BLA_IDX_AFIRST  = 8'h75;
   localparam logic [7:0] BLA_IDX_ASECOND = 8'h76;
   localparam logic [7:0] BLA_IDX_CONV    = 8'h77;

   // ----------------------------------------------------------------
   // Values after reset and writable bit masks
   // ----------------------------------------------------------------
   localparam logic [7:0] BLA_RST_CANCEL  = 8'h31;
   localparam logic [7:0] BLA_RST_AFIRST  = 8'h00;
   localparam logic [7:0] BLA_RST_ASECOND = 8'h00;
   localparam logic [7:0] BLA_RST_CONV    = 8'h5a;
   localparam logic [7:0] BLA_MSK_CANCEL  = 8'h3f;
   localparam logic [7:0] BLA_MSK_CONV    = 8'h7f;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int BLA_CAN_TC_LSB   = 2;
   localparam int BLA_CAN_NARROW   = 5;
   localparam int BLA_AF_CLAMP     = 0;
   localparam int BLA_AF_TEST      = 1;
   localparam int BLA_AF_WREF_LSB  = 2;
   localparam int BLA_AF_BLOOM     = 4;
   localparam int BLA_AF_PD_DIFF   = 5;
   localparam int BLA_AF_PD_SRAM   = 6;
   localparam int BLA_AF_PD_CCS    = 7;
   localparam int BLA_AS_STANDBY   = 0;
   localparam int BLA_AS_PD_RAMP   = 1;
   localparam int BLA_AS_PD_CADC   = 2;
   localparam int BLA_AS_COLUMN_REGULATOR_OFF   = 3;
   localparam int BLA_AS_AUDIO_REGULATOR_OFF   = 4;
   localparam int BLA_AS_PD_REFA   = 5;
   localparam int BLA_AS_RAMP_CM   = 6;
   localparam int BLA_AS_CMP_BIAS  = 7;
   localparam int BLA_CV_DOUBLER   = 2;
   localparam int BLA_CV_DIFFRAMP  = 3;
   localparam int BLA_CV_VIEWCAS   = 4;
   localparam int BLA_CV_TESTCMP   = 5;
   localparam int BLA_CV_STEPPED   = 6;

   // ----------------------------------------------------------------
   // Loop constants
   // ----------------------------------------------------------------
   localparam logic [11:0] BLA_DB_WIDE   = 12'h004;
   localparam logic [11:0] BLA_DB_NARROW = 12'h002;
   localparam int          BLA_FRAC_BITS = 7;
   localparam logic [9:0]  BLA_PIX_MAX   = 10'h3ff;

   // Cancellation modes; both codes with bit 0 clear apply nothing
   typedef enum logic [1:0] {
      BLA_MODE_OFF0 = 2'b00,
      BLA_MODE_INT  = 2'b01,
      BLA_MODE_OFF2 = 2'b10,
      BLA_MODE_EXT  = 2'b11
   } bla_mode_t;

   // Subtract a signed offset from a pixel and clamp to the code range
   function automatic logic [9:0] bla_sub_clamp(
      input logic [9:0]  pix,
      input logic [10:0] off
   );
      logic signed [12:0] diff;
      diff = $signed({3'b000, pix}) - $signed({{2{off[10]}}, off});
      if (diff < 0)
         return 10'h000;
      else if (diff > $signed({3'b000, BLA_PIX_MAX}))
         return BLA_PIX_MAX;
      else
         return diff[9:0];
   endfunction : bla_sub_clamp

endpackage : bla_pkg

// ### rtl/bla_loop_if.sv
`timescale 1ns/1ps
interface bla_loop_if;
   import bla_pkg::*;
   bla_mode_t   mode;
   logic [2:0]  tc;
   logic        narrow;
   logic [9:0]  avg;
   logic        avg_valid;
   logic [10:0] int_offset;

   modport ctrl (output mode, output tc, output narrow, output avg,
                 output avg_valid, input int_offset);
   modport loop (input mode, input tc, input narrow, input avg,
                 input avg_valid, output int_offset);
endinterface : bla_loop_if

// ### rtl/bla_black_loop.sv
`timescale 1ns/1ps
module bla_black_loop
   import bla_pkg::*;
#(
   parameter logic [9:0] TARGET = 10'h040
) (
   input  wire logic sys_clk_in,
   input  wire logic srst_in,
   bla_loop_if.loop  lp
);

   // ----------------------------------------------------------------
   // Saturating integrator
   // ----------------------------------------------------------------
   logic signed [17:0] integ_reg;
   logic signed [17:0] integ_next;
   logic signed [11:0] err;
   logic        [11:0] err_abs;
   logic        [11:0] band;
   logic signed [18:0] step;
   logic signed [18:0] sum;

   // Error step is scaled down by the time constant; a larger field
   // follows slower but rejects more frame-to-frame noise
   always_comb begin
      err     = $signed({2'b00, lp.avg}) - $signed({2'b00, TARGET});
      err_abs = err[11] ? 12'(-err) : err;
      band    = lp.narrow ? BLA_DB_NARROW : BLA_DB_WIDE;      // [RULE4]
      step    = $signed({{7{err[11]}}, err}) <<< BLA_FRAC_BITS;
      step    = step >>> lp.tc;                               // [RULE3]
      sum     = $signed({integ_reg[17], integ_reg}) + step;
      integ_next = integ_reg;
      if (lp.avg_valid && err_abs > band) begin               // [RULE4]
         if (sum > $signed(19'h1ffff))
            integ_next = 18'h1ffff;
         else if (sum < $signed(19'h60000))
            integ_next = 18'h20000;
         else
            integ_next = sum[17:0];
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (srst_in)
         integ_reg <= '0;
      else
         integ_reg <= integ_next;
   end

   // Whole codes of the estimate, 11-bit two's complement
   assign lp.int_offset = integ_reg[17:7];

   // Inside the deadband the integrator must not move
   a_hold_in_band: assert property (@(posedge sys_clk_in)
      disable iff (srst_in)
      (lp.avg_valid && err_abs <= band) |=> $stable(integ_reg)) // [RULE4]
      else $error("Integrator moved inside deadband");

endmodule : bla_black_loop

// ### bench/bla_host_model.sv
`timescale 1ns/1ps
// Stand-in for the serial bus master: one register byte per strobe
module bla_host_model (
   input  wire logic       sys_clk_in,
   input  wire logic [7:0] reg_rdata_in,
   output logic      [7:0] reg_index_out,
   output logic      [7:0] reg_wdata_out,
   output logic            reg_wr_out,
   output logic            reg_rd_out
);
   initial begin
      reg_index_out = 8'h00;
      reg_wdata_out = 8'h00;
      reg_wr_out    = 1'b0;
      reg_rd_out    = 1'b0;
   end

   // Indexed write; index and data are flipped once released
   task automatic wr_reg(input logic [7:0] idx, input logic [7:0] val);
      @(posedge sys_clk_in);
      reg_index_out <= idx;
      reg_wdata_out <= val;
      reg_wr_out    <= 1'b1;
      @(posedge sys_clk_in);
      reg_wr_out    <= 1'b0;
      reg_index_out <= ~idx;
      reg_wdata_out <= ~val;
   endtask : wr_reg

   // Indexed read; the data is registered, so it is taken an edge later
   task automatic rd_reg(input logic [7:0] idx, output logic [7:0] val);
      @(posedge sys_clk_in);
      reg_index_out <= idx;
      reg_rd_out    <= 1'b1;
      @(posedge sys_clk_in);
      reg_rd_out    <= 1'b0;
      reg_index_out <= ~idx;
      @(posedge sys_clk_in);
      val = reg_rdata_in;
   endtask : rd_reg
endmodule : bla_host_model

// ### bench/test_black_level_analog_setup_regs.sv
`timescale 1ns/1ps
module test_black_level_analog_setup_regs;
   import bla_pkg::*;
   logic        clk, srst, wr, rd, bv, pv, hit, pvo, avv;
   logic [7:0]  idx, wd, rdat, v, sh [4];
   logic [10:0] ext, x;
   logic [9:0]  bp, pix, po, avg;
   logic [31:0] seed;
   logic [22:0] o;
   int          n_fail, checked, cyc, e, io;
   logic [7:0]  ix [4] = '{8'h72, 8'h75, 8'h76, 8'h77};
   logic [7:0]  rs [4] = '{8'h31, 8'h00, 8'h00, 8'h5a};
   logic [7:0]  mk [4] = '{8'h3f, 8'hff, 8'hff, 8'h7f};

   bla_setup_regs #(.AVG_LOG2(2)) u_dut (.sys_clk_in(clk), .srst_in(srst),
      .reg_index_in(idx), .reg_wr_in(wr), .reg_rd_in(rd),
      .reg_wdata_in(wd), .reg_rdata_out(rdat), .reg_hit_out(hit),
      .ext_offset_in(ext), .black_pix_in(bp), .black_valid_in(bv),
      .pix_in(pix), .pix_valid_in(pv), .pix_out(po), .pix_valid_out(pvo),
      .black_avg_out(avg), .black_avg_valid_out(avv),
      .bl_clamp_en_out(o[0]), .bl_test_en_out(o[1]),
      .white_ref_sel_out(o[3:2]), .anti_bloom_en_out(o[4]),
      .diff_clk_cmp_off_out(o[5]), .sram_cmp_off_out(o[6]),
      .controlled_current_source_off_out(o[7]), .standby_out(o[8]),
      .ramp_gen_off_out(o[9]), .column_adc_off_out(o[10]),
      .column_regulator_off_out(o[11]), .audio_regulator_off_out(o[12]),
      .top_reference_voltage_amp_off_out(o[13]), .ramp_cm_sel_out(o[14]),
      .col_cmp_bias_sel_out(o[15]), .conv_reserved_out(o[17:16]),
      .doubler_en_out(o[18]), .diff_ramp_en_out(o[19]),
      .view_cascode_out(o[20]), .test_cmp_sel_out(o[21]),
      .stepped_ramp_out(o[22]));
   bla_host_model u_host (.sys_clk_in(clk), .reg_rdata_in(rdat),
      .reg_index_out(idx), .reg_wdata_out(wd), .reg_wr_out(wr),
      .reg_rd_out(rd));

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   // Hang guard: the whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         n_fail++;
         conclude();
      end
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction : xs
   task automatic chk(input logic [31:0] got, exp, input string m);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   // Control outputs must mirror the shadow registers bit for bit
   task automatic chk_outs();
      chk(o, {sh[3][6:0], sh[2], sh[1]}, "controls");
   endtask : chk_outs
   // Offset rides with the pixel; io is the offset the loop should hold
   task automatic px(input logic [9:0] p, input logic [10:0] xo,
                     input int m);
      @(posedge clk);
      pix <= p;
      ext <= xo;
      pv  <= 1'b1;
      @(posedge clk);
      pv  <= 1'b0;
      @(negedge clk);
      e = (m == 3) ? int'(p) - int'($signed(xo))
                   : (m == 1) ? int'(p) - io : int'(p);
      e = (e < 0) ? 0 : (e > 1023) ? 1023 : e;
      chk(pvo, 1, "pix valid");
      chk(po, e, "pixel");
   endtask : px
   // Four black samples of b, b+1, b+1, b+2 average to b+1
   task automatic blk(input logic [9:0] b);
      foreach (rs[k]) begin
         @(posedge clk);
         bv <= 1'b1;
         bp <= b + 10'(k > 0) + 10'(k > 2);
      end
      @(posedge clk);
      bv <= 1'b0;
      for (int w = 0; w < 3 && avv !== 1'b1; w++)
         @(negedge clk);
      chk({avv, avg}, {1'b1, b + 10'h001}, "black average");
   endtask : blk
   task automatic conclude();
      $display("counts: checked %0d n_fail %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude

   // ----------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------
   initial begin
      {srst, bv, pv, bp, pix, ext, n_fail, checked, cyc, io} = '0;
      srst = 1'b1;
      seed = 32'h5527985a;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      // Defaults after reset, read back and seen on the controls
      for (int i = 0; i < 4; i++) begin
         u_host.rd_reg(ix[i], v);
         chk(v, rs[i], "reset value");
         chk(hit, 1, "hit");
         sh[i] = rs[i];
      end
      chk_outs();
      $display("reset test done");
      // Random writes, masked read-back and control decode
      for (int k = 0; k < 12; k++) begin
         seed = xs(seed);
         u_host.wr_reg(ix[k%4], seed[7:0]);
         sh[k%4] = seed[7:0] & mk[k%4];
         #1 chk_outs();
         u_host.rd_reg(ix[k%4], v);
         chk(v, sh[k%4], "read back");
      end
      // Unmapped index: write ignored, reads zero without hit
      u_host.wr_reg(8'h73, 8'hff);
      u_host.rd_reg(8'h73, v);
      chk({hit, v}, 9'h000, "unmapped");
      chk_outs();
      // Host on a 3.3V supply turns the voltage doubler on
      u_host.wr_reg(8'h77, sh[3] | 8'h04);
      sh[3] = sh[3] | 8'h04;
      #1 chk_outs();
      $display("register test done");
      // Narrow band holds at +2; wide band holds at +4, then +8 with a
      // halving time constant leaves a 4-code internal offset
      u_host.wr_reg(8'h72, 8'h21);
      blk(10'h041);
      u_host.wr_reg(8'h72, 8'h05);
      blk(10'h043);
      blk(10'h047);
      io = 4;
      $display("average test done");
      // Every mode code, with random and extreme external offsets
      for (int m = 0; m < 4; m++) begin
         u_host.wr_reg(8'h72, 8'h20 | 8'(m));
         for (int k = 0; k < 6; k++) begin
            seed = xs(seed);
            x = (k == 0) ? 11'h400 : (k == 1) ? 11'h3ff : seed[26:16];
            px(seed[9:0], x, m);
         end
      end
      $display("pixel test done");
      conclude();
   end
endmodule : test_black_level_analog_setup_regs
